// ===== shared/nvm_pkg.sv
// Shared constants and types for the data EEPROM access control block
package nvm_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite port)
    // ------------------------------------------------------------
    localparam int NVM_AXI_AW = 5;
    localparam logic [4:0] NVM_OFS_CTRL = 5'h00;
    localparam logic [4:0] NVM_OFS_KEY = 5'h04;
    localparam logic [4:0] NVM_OFS_DATA = 5'h08;
    localparam logic [4:0] NVM_OFS_ADDR = 5'h0C;
    localparam logic [4:0] NVM_OFS_STATUS = 5'h10;
    localparam logic [4:0] NVM_OFS_CLEAR = 5'h14;
    localparam logic [4:0] NVM_OFS_ENABLE = 5'h18;

    // ------------------------------------------------------------
    // Array geometry, unlock key values, reset values
    // ------------------------------------------------------------
    localparam int NVM_DEPTH = 64;
    localparam int NVM_ADDR_W = 6;
    localparam int NVM_DATA_W = 8;
    localparam int NVM_CTRL_W = 5;
    localparam int NVM_WRITE_CYCLES = 2000;
    localparam logic [7:0] NVM_KEY_FIRST = 8'h55;
    localparam logic [7:0] NVM_KEY_SECOND = 8'hAA;
    localparam logic [4:0] NVM_CTRL_RESET = 5'h00;
    localparam logic [7:0] NVM_DATA_RESET = 8'h00;
    localparam logic [5:0] NVM_ADDR_RESET = 6'h00;
    localparam logic [1:0] NVM_IRQ_RESET = 2'h0;
    localparam logic [1:0] NVM_RESP_OKAY = 2'h0;
    localparam logic [1:0] NVM_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    // Control register, bit 0 is the read strobe
    typedef struct packed {
        logic doneFlag;
        logic abortFlag;
        logic writePermit;
        logic writeStrobe;
        logic readStrobe;
    } nvm_ctrl_t;

    // Interrupt status, clear and enable layout
    typedef struct packed {
        logic abortEvt;
        logic doneEvt;
    } nvm_irq_t;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_FIRST_SEEN,
        KEY_ARMED
    } nvm_key_state_t;

endpackage

// ===== design/nvm_access_ctrl.sv
// Data EEPROM access control with AXI4-Lite register port
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The address map and the AXI4-Lite slave port were left to the implementer.
module nvm_access_ctrl
    import nvm_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = NVM_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic extResetReq,
    input wire logic watchdogResetReq,
    input wire logic [NVM_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [NVM_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    nvm_ctrl_t ctrl, next_ctrl, wrCtrl;
    nvm_key_state_t keyState, next_keyState;
    logic [NVM_DATA_W-1:0] dataReg, next_dataReg, memOut;
    logic [NVM_ADDR_W-1:0] addrReg, next_addrReg;
    logic [CNT_W-1:0] count, next_count;
    nvm_irq_t irqEnable, next_irqEnable, irqStatus, wrIrq;
    logic [NVM_DATA_W-1:0] mem [NVM_DEPTH];
    logic resetEvt, writeEnd, commit, doWrite, regWrite, arFire;
    logic awHeld, next_awHeld, wHeld, next_wHeld, wLane, next_wLane;
    logic [NVM_AXI_AW-1:0] awAddr, next_awAddr;
    logic [7:0] wByte, next_wByte;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic isMapped(input logic [NVM_AXI_AW-1:0] a);
        case ({a[4:2], 2'h0})
            NVM_OFS_CTRL, NVM_OFS_KEY, NVM_OFS_DATA, NVM_OFS_ADDR,
            NVM_OFS_STATUS, NVM_OFS_CLEAR, NVM_OFS_ENABLE: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction
    function automatic logic [NVM_AXI_AW-1:0] wordOf(
        input logic [NVM_AXI_AW-1:0] a);
        wordOf = {a[4:2], 2'h0};
    endfunction

    assign irqStatus = '{abortEvt: ctrl.abortFlag, doneEvt: ctrl.doneFlag};
    assign irq = |(irqStatus & irqEnable);
    assign resetEvt = extResetReq | watchdogResetReq;
    assign memOut = mem[addrReg];

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !awHeld && !bvalid;
    assign s_axi_wready = !wHeld && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
    assign doWrite = awHeld && wHeld;
    assign regWrite = doWrite && wLane && isMapped(awAddr);
    assign arFire = s_axi_arvalid && !rvalid;
    assign wrCtrl = nvm_ctrl_t'(wByte[NVM_CTRL_W-1:0]);
    assign wrIrq = nvm_irq_t'(wByte[1:0]);

    always_comb begin
        next_awHeld = awHeld;
        next_awAddr = awAddr;
        next_wHeld = wHeld;
        next_wByte = wByte;
        next_wLane = wLane;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wByte = s_axi_wdata[7:0];
            next_wLane = s_axi_wstrb[0];
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = isMapped(awAddr) ? NVM_RESP_OKAY : NVM_RESP_SLVERR;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (arFire) begin
            next_rvalid = 1'b1;
            next_rresp = isMapped(s_axi_araddr) ? NVM_RESP_OKAY
                                                : NVM_RESP_SLVERR;
            next_rdata = 32'h0000_0000;
            case (wordOf(s_axi_araddr))
                NVM_OFS_CTRL: next_rdata = {27'h0, ctrl};
                NVM_OFS_DATA: next_rdata = {24'h0, dataReg};
                NVM_OFS_ADDR: next_rdata = {26'h0, addrReg};
                NVM_OFS_STATUS: next_rdata = {30'h0, irqStatus};
                NVM_OFS_ENABLE: next_rdata = {30'h0, irqEnable};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld <= 1'b0;
            awAddr <= '0;
            wHeld <= 1'b0;
            wByte <= 8'h00;
            wLane <= 1'b0;
            bvalid <= 1'b0;
            bresp <= NVM_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= NVM_RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            awHeld <= next_awHeld;
            awAddr <= next_awAddr;
            wHeld <= next_wHeld;
            wByte <= next_wByte;
            wLane <= next_wLane;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Control, unlock sequence and write cycle
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_keyState = keyState;
        next_dataReg = dataReg;
        next_addrReg = addrReg;
        next_count = count;
        next_irqEnable = irqEnable;
        writeEnd = 1'b0;
        if (ctrl.readStrobe) begin
            next_dataReg = memOut;
            next_ctrl.readStrobe = 1'b0;
        end
        if (ctrl.writeStrobe) begin
            if (count == '0) begin
                writeEnd = 1'b1;
                next_ctrl.writeStrobe = 1'b0;
            end else begin
                next_count = count - 1'b1;
            end
        end
        if (regWrite) begin
            // Any register write other than the next key step disarms
            next_keyState = KEY_IDLE;
            case (wordOf(awAddr))
                NVM_OFS_CTRL: begin
                    if (wrCtrl.readStrobe) begin
                        next_ctrl.readStrobe = 1'b1;
                    end
                    next_ctrl.writePermit = wrCtrl.writePermit;
                    if (!wrCtrl.abortFlag) begin
                        next_ctrl.abortFlag = 1'b0;
                    end
                    if (!wrCtrl.doneFlag) begin
                        next_ctrl.doneFlag = 1'b0;
                    end
                    if (wrCtrl.writeStrobe && keyState == KEY_ARMED &&
                        ctrl.writePermit && !ctrl.writeStrobe) begin
                        next_ctrl.writeStrobe = 1'b1;
                        next_count = CNT_W'(WRITE_CYCLES - 1);
                    end
                end
                NVM_OFS_KEY: begin
                    if (!ctrl.writeStrobe) begin
                        if (wByte == NVM_KEY_FIRST) begin
                            next_keyState = KEY_FIRST_SEEN;
                        end else if (wByte == NVM_KEY_SECOND &&
                                     keyState == KEY_FIRST_SEEN) begin
                            next_keyState = KEY_ARMED;
                        end
                    end
                end
                NVM_OFS_DATA: next_dataReg = wByte;
                NVM_OFS_ADDR: next_addrReg = wByte[NVM_ADDR_W-1:0];
                NVM_OFS_CLEAR: begin
                    if (wrIrq.abortEvt) begin
                        next_ctrl.abortFlag = 1'b0;
                    end
                    if (wrIrq.doneEvt) begin
                        next_ctrl.doneFlag = 1'b0;
                    end
                end
                NVM_OFS_ENABLE: next_irqEnable = wrIrq;
                default: next_keyState = KEY_IDLE;
            endcase
        end
        // Hardware sets win over software clears in the same cycle
        if (writeEnd) begin
            next_ctrl.doneFlag = 1'b1;
        end
        if (resetEvt) begin
            if (ctrl.writeStrobe) begin
                next_ctrl.abortFlag = 1'b1;
                next_ctrl.doneFlag = ctrl.doneFlag;
            end
            next_ctrl.writeStrobe = 1'b0;
            next_ctrl.readStrobe = 1'b0;
            next_ctrl.writePermit = 1'b0;
            next_keyState = KEY_IDLE;
            next_count = '0;
            next_dataReg = dataReg;
            next_addrReg = addrReg;
        end
    end
    assign commit = writeEnd && !resetEvt;
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= nvm_ctrl_t'(NVM_CTRL_RESET);
            keyState <= KEY_IDLE;
            dataReg <= NVM_DATA_RESET;
            addrReg <= NVM_ADDR_RESET;
            count <= '0;
            irqEnable <= nvm_irq_t'(NVM_IRQ_RESET);
        end else begin
            ctrl <= next_ctrl;
            keyState <= next_keyState;
            dataReg <= next_dataReg;
            addrReg <= next_addrReg;
            count <= next_count;
            irqEnable <= next_irqEnable;
        end
    end

    // Array content is nonvolatile and takes no reset
    always_ff @(posedge clk) begin
        if (commit) begin
            mem[addrReg] <= dataReg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    ctrl_upper_zero_a: assert property (
        arFire && wordOf(s_axi_araddr) == NVM_OFS_CTRL
        |=> s_axi_rvalid && s_axi_rdata[31:NVM_CTRL_W] == '0)
        else $error("control upper bits not zero");
    strobe_held_a: assert property (
        ctrl.writeStrobe && count != '0 && !resetEvt |=> ctrl.writeStrobe)
        else $error("write strobe dropped early");
    permit_reset_a: assert property (
        resetEvt |=> !ctrl.writePermit)
        else $error("write permit set after reset");
    abort_flag_a: assert property (
        ctrl.writeStrobe && resetEvt
        |=> ctrl.abortFlag && !ctrl.writeStrobe && $stable(addrReg)
            && $stable(dataReg))
        else $error("abort not recorded");
    done_flag_a: assert property (
        writeEnd && !resetEvt |=> ctrl.doneFlag && irqStatus.doneEvt)
        else $error("done flag not set");
    key_reads_zero_a: assert property (
        arFire && wordOf(s_axi_araddr) == NVM_OFS_KEY
        |=> s_axi_rdata == 32'h0000_0000)
        else $error("key register read not zero");
    read_latency_a: assert property (
        ctrl.readStrobe && !resetEvt
        |=> !ctrl.readStrobe && dataReg == $past(memOut))
        else $error("read data not loaded next cycle");
    data_hold_a: assert property (
        !$stable(dataReg)
        |-> $past(ctrl.readStrobe)
            || $past(regWrite && wordOf(awAddr) == NVM_OFS_DATA))
        else $error("data register changed without cause");
    write_start_a: assert property (
        $rose(ctrl.writeStrobe)
        |-> $past(keyState) == KEY_ARMED && $past(ctrl.writePermit))
        else $error("write started without unlock and permit");
    write_length_a: assert property (
        $rose(ctrl.writeStrobe) |-> count == CNT_W'(WRITE_CYCLES - 1))
        else $error("write cycle length wrong");
    permit_no_cancel_a: assert property (
        ctrl.writeStrobe && !ctrl.writePermit && count != '0 && !resetEvt
        |=> ctrl.writeStrobe)
        else $error("clearing permit cancelled write");
endmodule

// ===== bench/testbench.sv
// Self-checking testbench for the data EEPROM access control block
module testbench
    import nvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------
    localparam int WC = 40;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic extResetReq = 1'b0;
    logic watchdogResetReq = 1'b0;
    logic [NVM_AXI_AW-1:0] s_axi_awaddr = '0;
    logic [NVM_AXI_AW-1:0] s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, irq;
    logic [3:0] strb = 4'hF;
    logic [1:0] expResp = NVM_RESP_OKAY;
    int n_fail = 0;
    int check_count = 0;

    nvm_access_ctrl #(
        .WRITE_CYCLES(WC)
    ) i_nvm_access_ctrl (
        .clk(clk),
        .srst(srst),
        .extResetReq(extResetReq),
        .watchdogResetReq(watchdogResetReq),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .irq(irq)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic timeout();
        n_fail++;
        $display("Error handshake wait ran out");
        final_report();
    endtask

    // ------------------------------------------------------------
    // AXI4-Lite master tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bit ah, wh, bh;
        logic [1:0] r;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) begin
                s_axi_bready <= 1'b0;
                check($sformatf("bresp %h", a), {30'h0, r}, {30'h0, expResp});
                return;
            end
        end
        timeout();
    endtask

    task automatic ard(input logic [4:0] a, output logic [31:0] d);
        bit ah, rh;
        logic [1:0] r;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) begin
                s_axi_rready <= 1'b0;
                check($sformatf("rresp %h", a), {30'h0, r}, {30'h0, expResp});
                return;
            end
        end
        timeout();
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ard(a, v);
        check($sformatf("reg %h", a), v, exp);
    endtask

    // ------------------------------------------------------------
    // EEPROM sequences
    // ------------------------------------------------------------
    task automatic eeprog(input logic [7:0] a, input logic [7:0] d);
        wr(NVM_OFS_ADDR, a);
        wr(NVM_OFS_DATA, d);
        wr(NVM_OFS_KEY, NVM_KEY_FIRST);
        wr(NVM_OFS_KEY, NVM_KEY_SECOND);
        wr(NVM_OFS_CTRL, 8'h06);
    endtask

    task automatic wait_idle();
        logic [31:0] v;
        for (int i = 0; i < 100; i++) begin
            ard(NVM_OFS_CTRL, v);
            if (v[1] === 1'b0) return;
        end
        timeout();
    endtask

    task automatic rdee(input logic [7:0] a, input logic [7:0] exp);
        wr(NVM_OFS_ADDR, a);
        wr(NVM_OFS_CTRL, 8'h01);
        rdc(NVM_OFS_DATA, {24'h0, exp});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rdc(NVM_OFS_CTRL, 32'h0);
        rdc(NVM_OFS_KEY, 32'h0);
        rdc(NVM_OFS_DATA, 32'h0);
        rdc(NVM_OFS_STATUS, 32'h0);
        check("irq", irq, 32'h0);
        wr(NVM_OFS_CTRL, 8'hE0);
        rdc(NVM_OFS_CTRL, 32'h0);
        wr(NVM_OFS_KEY, NVM_KEY_FIRST);
        wr(NVM_OFS_KEY, NVM_KEY_SECOND);
        wr(NVM_OFS_CTRL, 8'h02);
        rdc(NVM_OFS_CTRL, 32'h0);
        wr(NVM_OFS_ENABLE, 8'h01);
        wr(NVM_OFS_CTRL, 8'h04);
        eeprog(8'h3F, 8'hA5);
        rdc(NVM_OFS_CTRL, 32'h06);
        wr(NVM_OFS_CTRL, 8'h04);
        rdc(NVM_OFS_CTRL, 32'h06);
        // Unlock steps given while busy must not arm the next write
        wr(NVM_OFS_KEY, NVM_KEY_FIRST);
        wr(NVM_OFS_KEY, NVM_KEY_SECOND);
        wait_idle();
        rdc(NVM_OFS_CTRL, 32'h14);
        wr(NVM_OFS_CTRL, 8'h16);
        rdc(NVM_OFS_CTRL, 32'h14);
        check("irq", irq, 32'h1);
        wr(NVM_OFS_CLEAR, 8'h01);
        check("irq", irq, 32'h0);
        eeprog(8'h00, 8'h5A);
        wr(NVM_OFS_CTRL, 8'h00);
        wait_idle();
        rdc(NVM_OFS_CTRL, 32'h10);
        wr(NVM_OFS_CLEAR, 8'h03);
        rdee(8'h3F, 8'hA5);
        rdc(NVM_OFS_CTRL, 32'h0);
        rdee(8'h00, 8'h5A);
        wr(NVM_OFS_ADDR, 8'h3F);
        rdc(NVM_OFS_DATA, 32'h5A);
        strb = 4'h0;
        wr(NVM_OFS_ADDR, 8'h2A);
        strb = 4'hF;
        rdc(NVM_OFS_ADDR, 32'h3F);
        // Broken unlock orders must never start a write
        wr(NVM_OFS_CTRL, 8'h04);
        for (int k = 0; k < 3; k++) begin
            wr(NVM_OFS_KEY, k == 0 ? NVM_KEY_SECOND : NVM_KEY_FIRST);
            if (k == 0) wr(NVM_OFS_KEY, NVM_KEY_FIRST);
            if (k == 1) wr(NVM_OFS_DATA, 8'h11);
            if (k == 1) wr(NVM_OFS_KEY, NVM_KEY_SECOND);
            wr(NVM_OFS_CTRL, 8'h06);
            rdc(NVM_OFS_CTRL, 32'h04);
        end
        // Pin reset, then watchdog reset, in mid-write
        for (int k = 0; k < 2; k++) begin
            wr(NVM_OFS_ENABLE, 8'h02);
            wr(NVM_OFS_CTRL, 8'h04);
            eeprog(8'h10, 8'h3C);
            @(posedge clk);
            extResetReq <= (k == 0);
            watchdogResetReq <= (k == 1);
            @(posedge clk);
            extResetReq <= 1'b0;
            watchdogResetReq <= 1'b0;
            rdc(NVM_OFS_CTRL, 32'h08);
            rdc(NVM_OFS_STATUS, 32'h02);
            check("irq", irq, 32'h1);
            rdc(NVM_OFS_DATA, 32'h3C);
            rdc(NVM_OFS_ADDR, 32'h10);
            wr(NVM_OFS_ENABLE, 8'h00);
            check("irq", irq, 32'h0);
            wr(NVM_OFS_CLEAR, 8'h02);
            rdc(NVM_OFS_STATUS, 32'h0);
        end
        expResp = NVM_RESP_SLVERR;
        wr(5'h1C, 8'hFF);
        rdc(5'h1C, 32'h0);
        final_report();
    end
endmodule
